// file: rtl/emsm_top.sv
// emsm_top: energy mode state machine with its AXI4-Lite register slave.
// assumes: sleepReq pulses once per wait instruction of the core,
// isrActive is high while any handler runs, wake levels are enabled
// sources already; asyncWake comes from pins and is synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "emsm_params.svh"

// What this block does
// R1 - after any reset the block sits in active mode with everything running
// R2 - only software requests leave active mode for a low energy mode
// R3 - enabled interrupt or event returns sleep to active; deep sleep and stop return only on R17, R18 sources
// R4 - shutoff is left only by pin or power-on reset
// R5 - no direct move between sleep, deep sleep and stop modes
// R6 - the processor executes nothing in any low energy mode
// R7 - select bits pick sleep or deep sleep as tabled
// R8 - a wait-for-interrupt or wait-for-event request enters the chosen mode
// R9 - sleep on isr exit delays entry until the last handler ends
// R10 - shutoff follows the write sequence 2,3,2,3,2,3,2,3,2 alone
// R11 - writing zero to the sequence field restarts the sequence
// R12 - deep sleep block turns deep requests into sleep mode
// R13 - keep regulator on holds the regulator, acting as sleep mode
// R14 - software stops both low frequency clocks before asking for stop mode
// R15 - sleep gates the cpu clock, keeps high frequency oscillator and trees
// R16 - deep sleep stops high frequency parts, keeps low frequency ones
// R17 - deep sleep wakes on peripheral or pin interrupt, keeps ram
// R18 - stop wakes only on pin, address match or comparator edge
// R19 - in stop the watchdog runs only on the ultra low oscillator
// R20 - shutoff turns every oscillator and regulator off, memory is lost
// R21 - an out of order sequence value restarts the sequence
module emsm_top (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`EMSM_AW-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`EMSM_AW-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic sleepReq,
  input wire logic isrActive,
  input wire logic irqWake,
  input wire logic lfIrqWake,
  input wire emsm_pkg::emsm_async_t asyncWake,
  input wire logic lfaClkOn,
  input wire logic lfbClkOn,
  output emsm_pkg::emsm_pwr_t pwrCtl,
  output emsm_pkg::emsm_mode_t energyMode
);

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic rstMeta_q;
  logic rstSyncN;

  // asserted at once, released two edges later
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_q <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSyncN <= rstMeta_q;
    end
  end

  // ----------------------------------------------------------------------
  // state and constants
  // ----------------------------------------------------------------------
  localparam emsm_pkg::emsm_pwr_t PWR_ALL = 8'hFF;
  localparam emsm_pkg::emsm_pwr_t PWR_NONE = 8'h00;

  emsm_pkg::emsm_state_t st_q;
  emsm_pkg::emsm_state_t st_d;
  logic seqFire;
  logic wakeAsync;
  logic goLow;

  // shutoff sequence tracker fed by control register writes
  emsm_shutoff_seq u_seq (
    .core_clk(core_clk),
    .rstSyncN(rstSyncN),
    .wrEn(st_q.seqWr),
    .wrVal(st_q.seqVal),
    .fire(seqFire)
  );

  // only the second sync stage is looked at
  assign wakeAsync = st_q.wake2.pin | st_q.wake2.i2cAddr | st_q.wake2.acmpEdge;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.seqWr = 1'b0;
    goLow = 1'b0;

    // pin sources cross in through two flops
    st_d.wake1 = asyncWake;
    st_d.wake2 = st_q.wake1;

    // write address and data are taken in either order
    if (awvalid && st_q.awready) begin
      st_d.awHeld = 1'b1;
      st_d.awAddr = awaddr;
    end
    if (wvalid && st_q.wready) begin
      st_d.wHeld = 1'b1;
      st_d.wLow = wdata[3:0];
      st_d.wStrb0 = wstrb[0];
    end
    if (st_q.bvalid && bready) begin
      st_d.bvalid = 1'b0;
    end

    // commit one cycle after both halves are held
    if (st_q.awHeld && st_q.wHeld) begin
      st_d.awHeld = 1'b0;
      st_d.wHeld = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = `EMSM_RESP_OKAY;
      case (st_q.awAddr)
        `EMSM_OFF_CTRL: begin
          // every field lives in byte lane 0
          if (st_q.wStrb0) begin
            st_d.ctrl = st_q.wLow;
            st_d.seqWr = 1'b1;
            st_d.seqVal = st_q.wLow[3:2];
          end
        end
        `EMSM_OFF_CORECFG: begin
          if (st_q.wStrb0) begin
            st_d.deepSel = st_q.wLow[`EMSM_CFG_DEEP];
            st_d.onExit = st_q.wLow[`EMSM_CFG_ONEXIT];
            st_d.wdUlf = st_q.wLow[`EMSM_CFG_WDULF];
          end
        end
        `EMSM_OFF_STATUS: begin
          // read only, write accepted and dropped
        end
        default: begin
          st_d.bresp = `EMSM_RESP_SLVERR;
        end
      endcase
    end
    // one write in flight; the response blocks the next one
    st_d.awready = !st_d.awHeld && !st_d.bvalid;
    st_d.wready = !st_d.wHeld && !st_d.bvalid;

    // read channel answers one cycle after the address is taken
    if (st_q.rvalid && rready) begin
      st_d.rvalid = 1'b0;
    end
    if (arvalid && st_q.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = `EMSM_RESP_OKAY;
      case (araddr)
        `EMSM_OFF_CTRL: begin
          st_d.rdata = {28'h0000000, st_q.ctrl};
        end
        `EMSM_OFF_CORECFG: begin
          st_d.rdata = {29'h0000000, st_q.wdUlf, st_q.onExit, st_q.deepSel};
        end
        `EMSM_OFF_STATUS: begin
          st_d.rdata = {28'h0000000, st_q.pend, st_q.mode};
        end
        default: begin
          st_d.rdata = 32'h00000000;
          st_d.rresp = `EMSM_RESP_SLVERR;
        end
      endcase
    end
    st_d.arready = !st_d.rvalid;

    // mode sequencing; a chip reset is the async reset below, see R4
    case (st_q.mode)
      emsm_pkg::MODE_ACTIVE: begin
        if (seqFire) begin
          st_d.mode = emsm_pkg::MODE_SHUTOFF; // see R10
          st_d.pend = 1'b0;
        end else if (sleepReq && st_q.onExit && isrActive) begin
          st_d.pend = 1'b1; // wait for the last handler to leave, see R9
        end else if (sleepReq || (st_q.pend && !isrActive)) begin
          goLow = 1'b1; // only the core's request starts this, see R2 see R8
          st_d.pend = 1'b0;
        end
        // a half written shutoff sequence vetoes ordinary entry
        if (goLow && st_q.ctrl.seqField == 2'h0) begin
          if (!st_q.deepSel) begin
            st_d.mode = emsm_pkg::MODE_SLEEP; // see R7
          end else if (st_q.ctrl.dsBlock || st_q.ctrl.regOn) begin
            st_d.mode = emsm_pkg::MODE_SLEEP; // see R12 see R13
          end else if (!lfaClkOn && !lfbClkOn) begin
            st_d.mode = emsm_pkg::MODE_STOP; // software stopped both, see R14
          end else begin
            st_d.mode = emsm_pkg::MODE_DEEP; // see R7
          end
        end
      end
      emsm_pkg::MODE_SLEEP: begin
        if (irqWake || lfIrqWake || wakeAsync) begin
          st_d.mode = emsm_pkg::MODE_ACTIVE; // see R3 see R5
        end
      end
      emsm_pkg::MODE_DEEP: begin
        if (lfIrqWake || wakeAsync) begin
          st_d.mode = emsm_pkg::MODE_ACTIVE; // see R17 see R5
        end
      end
      emsm_pkg::MODE_STOP: begin
        if (wakeAsync) begin
          st_d.mode = emsm_pkg::MODE_ACTIVE; // see R18 see R5
        end
      end
      emsm_pkg::MODE_SHUTOFF: begin
        st_d.mode = emsm_pkg::MODE_SHUTOFF; // deaf to wakeups, see R4
      end
      default: begin
        st_d.mode = emsm_pkg::MODE_ACTIVE;
      end
    endcase

    // gates follow the next mode so they switch with it
    case (st_d.mode)
      emsm_pkg::MODE_ACTIVE: begin
        st_d.pwr = PWR_ALL;
      end
      emsm_pkg::MODE_SLEEP: begin
        st_d.pwr = PWR_ALL;
        st_d.pwr.cpuClk = 1'b0; // see R15 see R6
      end
      emsm_pkg::MODE_DEEP: begin
        st_d.pwr = PWR_NONE; // see R16 see R6
        st_d.pwr.lfOsc = 1'b1;
        st_d.pwr.lfClk = 1'b1;
        st_d.pwr.coreReg = st_d.ctrl.regOn;
        st_d.pwr.ramRetain = 1'b1; // see R17
        st_d.pwr.wdogRun = 1'b1;
      end
      emsm_pkg::MODE_STOP: begin
        st_d.pwr = PWR_NONE;
        st_d.pwr.ramRetain = 1'b1;
        st_d.pwr.wdogRun = st_d.wdUlf; // see R19
      end
      emsm_pkg::MODE_SHUTOFF: begin
        st_d.pwr = PWR_NONE; // see R20
      end
      default: begin
        st_d.pwr = PWR_ALL;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      st_q <= '0;
      st_q.mode <= emsm_pkg::MODE_ACTIVE; // see R1
      st_q.pwr <= PWR_ALL;
      st_q.ctrl <= `EMSM_CTRL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------------
  assign awready = st_q.awready;
  assign wready = st_q.wready;
  assign bvalid = st_q.bvalid;
  assign bresp = st_q.bresp;
  assign arready = st_q.arready;
  assign rvalid = st_q.rvalid;
  assign rdata = st_q.rdata;
  assign rresp = st_q.rresp;
  assign pwrCtl = st_q.pwr;
  assign energyMode = st_q.mode;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSyncN);

  sequence s_idle_req;
    energyMode == emsm_pkg::MODE_ACTIVE && sleepReq && !seqFire &&
      st_q.ctrl.seqField == 2'h0 && !(st_q.onExit && isrActive);
  endsequence

  sequence s_sleep_req;
    s_idle_req ##0 !st_q.deepSel;
  endsequence

  sequence s_block_req;
    s_idle_req ##0 st_q.deepSel && st_q.ctrl.dsBlock;
  endsequence

  property p_reset_active;
    $rose(rstSyncN) |-> energyMode == emsm_pkg::MODE_ACTIVE && pwrCtl == PWR_ALL;
  endproperty
  a_reset_active: assert property (p_reset_active) else $error("not active after reset"); // see R1

  property p_no_hw_entry;
    energyMode == emsm_pkg::MODE_ACTIVE && !sleepReq && !st_q.pend && !seqFire
      |=> energyMode == emsm_pkg::MODE_ACTIVE;
  endproperty
  a_no_hw_entry: assert property (p_no_hw_entry) else $error("left active unasked"); // see R2

  property p_wake_sleep;
    energyMode == emsm_pkg::MODE_SLEEP && irqWake |=> energyMode == emsm_pkg::MODE_ACTIVE;
  endproperty
  a_wake_sleep: assert property (p_wake_sleep) else $error("sleep ignored wakeup"); // see R3

  property p_shutoff_hold;
    energyMode == emsm_pkg::MODE_SHUTOFF |=> energyMode == emsm_pkg::MODE_SHUTOFF;
  endproperty
  a_shutoff_hold: assert property (p_shutoff_hold) else $error("left shutoff"); // see R4

  property p_no_lateral;
    energyMode inside {emsm_pkg::MODE_SLEEP, emsm_pkg::MODE_DEEP, emsm_pkg::MODE_STOP}
      |=> energyMode == $past(energyMode) || energyMode == emsm_pkg::MODE_ACTIVE;
  endproperty
  a_no_lateral: assert property (p_no_lateral) else $error("lateral mode move"); // see R5

  property p_cpu_off;
    energyMode != emsm_pkg::MODE_ACTIVE |-> !pwrCtl.cpuClk;
  endproperty
  a_cpu_off: assert property (p_cpu_off) else $error("cpu clocked while low"); // see R6

  property p_sleep_entry;
    s_sleep_req |=> energyMode == emsm_pkg::MODE_SLEEP && pwrCtl.hfOsc && pwrCtl.hfPerClk;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered"); // see R7

  property p_isr_delay;
    energyMode == emsm_pkg::MODE_ACTIVE && sleepReq && st_q.onExit && isrActive && !seqFire
      |=> energyMode == emsm_pkg::MODE_ACTIVE && st_q.pend;
  endproperty
  a_isr_delay: assert property (p_isr_delay) else $error("entry not delayed"); // see R9

  property p_deep_block;
    s_block_req |=> energyMode == emsm_pkg::MODE_SLEEP;
  endproperty
  a_deep_block: assert property (p_deep_block) else $error("block ignored"); // see R12

  property p_stop_wdog;
    energyMode == emsm_pkg::MODE_STOP |-> pwrCtl.wdogRun == st_q.wdUlf && !pwrCtl.lfOsc;
  endproperty
  a_stop_wdog: assert property (p_stop_wdog) else $error("stop gating wrong"); // see R19

endmodule
`default_nettype wire

// file: rtl/emsm_params.svh
// emsm_params.svh: offsets, field positions, reset values and sequence
// codes of the energy mode state machine.
// assumes: included by bare name, definitions only.
`ifndef EMSM_PARAMS_SVH
`define EMSM_PARAMS_SVH

// ----------------------------------------------------------------------
// register map (byte addresses, 12-bit window)
// ----------------------------------------------------------------------
`define EMSM_AW 12
`define EMSM_OFF_CTRL 12'h000
`define EMSM_OFF_CORECFG 12'h010
`define EMSM_OFF_STATUS 12'h014

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define EMSM_CTRL_RST 4'h0
`define EMSM_CFG_DEEP 0
`define EMSM_CFG_ONEXIT 1
`define EMSM_CFG_WDULF 2

// ----------------------------------------------------------------------
// shutoff write sequence: 2,3,2,3,2,3,2,3,2
// ----------------------------------------------------------------------
`define EMSM_SEQ_EVEN 2'h2
`define EMSM_SEQ_ODD 2'h3
`define EMSM_SEQ_LAST 4'h8

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define EMSM_RESP_OKAY 2'h0
`define EMSM_RESP_SLVERR 2'h2

`endif

// file: rtl/emsm_pkg.sv
// emsm_pkg: types shared by the energy mode state machine files.
// assumes: emsm_params.svh sits on the include path.
`include "emsm_params.svh"

package emsm_pkg;

  // ----------------------------------------------------------------------
  // modes and carriers
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_ACTIVE,
    MODE_SLEEP,
    MODE_DEEP,
    MODE_STOP,
    MODE_SHUTOFF
  } emsm_mode_t;

  // power and clock gates, one bit per resource, 1 = running
  typedef struct packed {
    logic cpuClk;
    logic hfOsc;
    logic hfPerClk;
    logic lfOsc;
    logic lfClk;
    logic coreReg;
    logic ramRetain;
    logic wdogRun;
  } emsm_pwr_t;

  // wakeup sources that arrive from outside the clock domain
  typedef struct packed {
    logic pin;
    logic i2cAddr;
    logic acmpEdge;
  } emsm_async_t;

  // energy_control_register layout, bit 3 down to bit 0
  typedef struct packed {
    logic [1:0] seqField;
    logic dsBlock;
    logic regOn;
  } emsm_ctrl_t;

  // ----------------------------------------------------------------------
  // module state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] cnt;
    logic fire;
  } emsm_seq_t;

  typedef struct packed {
    emsm_mode_t mode;
    emsm_pwr_t pwr;
    emsm_ctrl_t ctrl;
    logic deepSel;
    logic onExit;
    logic wdUlf;
    logic pend;
    emsm_async_t wake1;
    emsm_async_t wake2;
    logic seqWr;
    logic [1:0] seqVal;
    logic awready;
    logic wready;
    logic awHeld;
    logic wHeld;
    logic [`EMSM_AW-1:0] awAddr;
    logic [3:0] wLow;
    logic wStrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } emsm_state_t;

endpackage

// file: rtl/emsm_shutoff_seq.sv
// emsm_shutoff_seq: tracks the ordered writes that arm shutoff_mode.
// assumes: one write strobe per register write, same clock, synced reset.
`timescale 1ns/1ps
`default_nettype none
`include "emsm_params.svh"

module emsm_shutoff_seq (
  input wire logic core_clk,
  input wire logic rstSyncN,
  input wire logic wrEn,
  input wire logic [1:0] wrVal,
  output logic fire
);

  emsm_pkg::emsm_seq_t st_q;
  emsm_pkg::emsm_seq_t st_d;
  logic [1:0] expect_v;

  // even positions want 2, odd positions want 3
  assign expect_v = st_q.cnt[0] ? `EMSM_SEQ_ODD : `EMSM_SEQ_EVEN;

  // advance on a match, fall back to the start on anything else
  always_comb begin
    st_d = st_q;
    st_d.fire = 1'b0;
    if (wrEn) begin
      if (wrVal == expect_v) begin
        if (st_q.cnt == `EMSM_SEQ_LAST) begin
          st_d.fire = 1'b1; // see R10
          st_d.cnt = 4'h0;
        end else begin
          st_d.cnt = st_q.cnt + 4'h1;
        end
      end else begin
        st_d.cnt = 4'h0; // zero or wrong value restarts, see R11 see R21
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign fire = st_q.fire;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSyncN);

  property p_seq_fire;
    fire |-> $past(wrEn) && $past(wrVal) == `EMSM_SEQ_EVEN && $past(st_q.cnt) == `EMSM_SEQ_LAST;
  endproperty
  a_seq_fire: assert property (p_seq_fire) else $error("shutoff fired off sequence"); // see R10

  property p_seq_zero;
    wrEn && wrVal == 2'h0 |=> st_q.cnt == 4'h0 && !fire;
  endproperty
  a_seq_zero: assert property (p_seq_zero) else $error("zero write kept progress"); // see R11

  property p_seq_wrong;
    wrEn && wrVal != expect_v |=> st_q.cnt == 4'h0;
  endproperty
  a_seq_wrong: assert property (p_seq_wrong) else $error("wrong value kept progress"); // see R21

endmodule
`default_nettype wire

// file: verif/emsm_core_model.sv
// emsm_core_model: processor core and wakeup sources in front of the block.
// assumes: tasks are called one at a time from the bench's main process.
`timescale 1ns/1ps
`default_nettype none

module emsm_core_model (
  input wire logic core_clk,
  output logic sleepReq,
  output logic isrActive,
  output logic irqWake,
  output logic lfIrqWake,
  output emsm_pkg::emsm_async_t asyncWake,
  output logic lfaClkOn,
  output logic lfbClkOn
);
  // ----
  // idle levels, low frequency clocks running
  // ----
  initial begin
    sleepReq = 1'b0;
    isrActive = 1'b0;
    irqWake = 1'b0;
    lfIrqWake = 1'b0;
    asyncWake = 3'h0;
    lfaClkOn = 1'b1;
    lfbClkOn = 1'b1;
  end

  // one wait instruction after gap cycles; a single-cycle pulse
  task automatic wait_interrupt_instruction(input int gap);
    repeat (gap + 1) @(posedge core_clk);
    sleepReq <= 1'b1;
    @(posedge core_clk);
    sleepReq <= 1'b0;
  endtask

  // wake source: 0 irq, 1 low freq irq, 2 pin, 3 address match, 4 comparator
  task automatic wake(input int src, input int hold);
    @(posedge core_clk);
    case (src)
      0: irqWake <= 1'b1;
      1: lfIrqWake <= 1'b1;
      2: asyncWake.pin <= 1'b1;
      3: asyncWake.i2cAddr <= 1'b1;
      default: asyncWake.acmpEdge <= 1'b1;
    endcase
    repeat (hold) @(posedge core_clk);
    irqWake <= 1'b0;
    lfIrqWake <= 1'b0;
    asyncWake <= 3'h0;
  endtask

  // software switches both low frequency clocks together, off before stop
  task automatic lf_clocks(input logic on);
    @(posedge core_clk);
    lfaClkOn <= on;
    lfbClkOn <= on;
  endtask

  // handler running level
  task automatic isr(input logic on);
    @(posedge core_clk);
    isrActive <= on;
  endtask
endmodule

`default_nettype wire

// file: verif/tb_top.sv
// tb_top: self-checking bench for the energy mode state machine.
// assumes: AXI4-Lite register slave, core model on the mode inputs.
`timescale 1ns/1ps
`default_nettype none
`include "emsm_params.svh"

module tb_top;
  logic core_clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic sleepReq, isrActive, irqWake, lfIrqWake, lfaClkOn, lfbClkOn;
  emsm_pkg::emsm_async_t asyncWake;
  emsm_pkg::emsm_pwr_t pwrCtl;
  emsm_pkg::emsm_mode_t energyMode;
  int failures, checks_done, n;
  int badRun[10] = '{2, 3, 2, 0, 3, 2, 3, 2, 3, 2};
  int goodRun[11] = '{2, 3, 3, 2, 3, 2, 3, 2, 3, 2, 3};

  // ----
  // clock, design and partner
  // ----
  always #2.5 core_clk = ~core_clk;

  emsm_top DUT (.core_clk(core_clk), .rstn(rstn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .sleepReq(sleepReq), .isrActive(isrActive),
    .irqWake(irqWake), .lfIrqWake(lfIrqWake), .asyncWake(asyncWake),
    .lfaClkOn(lfaClkOn), .lfbClkOn(lfbClkOn), .pwrCtl(pwrCtl), .energyMode(energyMode));

  emsm_core_model core (.core_clk(core_clk), .sleepReq(sleepReq), .isrActive(isrActive),
    .irqWake(irqWake), .lfIrqWake(lfIrqWake), .asyncWake(asyncWake),
    .lfaClkOn(lfaClkOn), .lfbClkOn(lfbClkOn));

  // ----
  // reporting
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // a wait that ran out of cycles ends the run
  task automatic tick();
    @(posedge core_clk);
    n++;
    if (n > 60) begin
      failures++;
      $display("[ERR] %0t wait bound used up", $time);
      close_out();
    end
  endtask

  // ----
  // bus and mode helpers
  // ----
  // address and data offered together, each released when taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      tick();
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      tick();
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    axi_wr(a, d);
    check({30'h0, resp}, {30'h0, `EMSM_RESP_OKAY});
  endtask

  // wait, bounded, for a mode change, then compare mode and gates
  task automatic wait_mode(input emsm_pkg::emsm_mode_t m, input logic [7:0] p);
    n = 0;
    while (energyMode !== m) tick();
    check({29'h0, energyMode}, {29'h0, m});
    check({24'h0, pwrCtl}, {24'h0, p});
  endtask

  // mode must still match after eight cycles
  task automatic hold(input emsm_pkg::emsm_mode_t m);
    repeat (8) @(posedge core_clk);
    check({29'h0, energyMode}, {29'h0, m});
  endtask

  task automatic rst_cycle();
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hF;
    failures = 0;
    checks_done = 0;
    rst_cycle();
    wait_mode(emsm_pkg::MODE_ACTIVE, 8'hFF);
    axi_rd(`EMSM_OFF_CTRL);
    check(rd, 32'h0);
    axi_rd(12'h004);
    check({rd[29:0], resp}, {30'h0, `EMSM_RESP_SLVERR});
    axi_wr(12'h024, 32'h1);
    check({30'h0, resp}, {30'h0, `EMSM_RESP_SLVERR});
    $display("test reset done");
    for (int s = 0; s < 5; s++) core.wake(s, 4);
    hold(emsm_pkg::MODE_ACTIVE);
    $display("test no hardware exit done");
    core.wait_interrupt_instruction(0);
    wait_mode(emsm_pkg::MODE_SLEEP, 8'h7F);
    axi_rd(`EMSM_OFF_STATUS);
    check(rd, 32'h1);
    check({30'h0, resp}, {30'h0, `EMSM_RESP_OKAY});
    wr(`EMSM_OFF_CORECFG, 32'h1);
    core.wait_interrupt_instruction(0);
    hold(emsm_pkg::MODE_SLEEP);
    core.wake(0, 2);
    wait_mode(emsm_pkg::MODE_ACTIVE, 8'hFF);
    core.wait_interrupt_instruction(3);
    wait_mode(emsm_pkg::MODE_DEEP, 8'h1B);
    core.wake(0, 4);
    hold(emsm_pkg::MODE_DEEP);
    core.wake(1, 2);
    wait_mode(emsm_pkg::MODE_ACTIVE, 8'hFF);
    $display("test sleep and deep done");
    for (int v = 1; v < 3; v++) begin
      wr(`EMSM_OFF_CTRL, 32'(v));
      core.wait_interrupt_instruction(0);
      wait_mode(emsm_pkg::MODE_SLEEP, 8'h7F);
      core.wake(0, 2);
      wait_mode(emsm_pkg::MODE_ACTIVE, 8'hFF);
    end
    wr(`EMSM_OFF_CTRL, 32'h0);
    wstrb <= 4'hE;
    wr(`EMSM_OFF_CTRL, 32'h2);
    wstrb <= 4'hF;
    axi_rd(`EMSM_OFF_CTRL);
    check(rd, 32'h0);
    $display("test block and regulator done");
    core.lf_clocks(1'b0);
    core.wait_interrupt_instruction(0);
    wait_mode(emsm_pkg::MODE_STOP, 8'h02);
    core.wake(1, 4);
    hold(emsm_pkg::MODE_STOP);
    core.wake(3, 2);
    wait_mode(emsm_pkg::MODE_ACTIVE, 8'hFF);
    wr(`EMSM_OFF_CORECFG, 32'h5);
    axi_rd(`EMSM_OFF_CORECFG);
    check(rd, 32'h5);
    core.wait_interrupt_instruction(0);
    wait_mode(emsm_pkg::MODE_STOP, 8'h03);
    core.wake(4, 2);
    wait_mode(emsm_pkg::MODE_ACTIVE, 8'hFF);
    core.lf_clocks(1'b1);
    $display("test stop done");
    wr(`EMSM_OFF_CORECFG, 32'h2);
    core.isr(1'b1);
    core.wait_interrupt_instruction(0);
    hold(emsm_pkg::MODE_ACTIVE);
    axi_rd(`EMSM_OFF_STATUS);
    check(rd, 32'h8);
    core.isr(1'b0);
    wait_mode(emsm_pkg::MODE_SLEEP, 8'h7F);
    core.wake(0, 2);
    wait_mode(emsm_pkg::MODE_ACTIVE, 8'hFF);
    $display("test handler exit done");
    foreach (badRun[i]) wr(`EMSM_OFF_CTRL, 32'(badRun[i] << 2));
    hold(emsm_pkg::MODE_ACTIVE);
    wr(`EMSM_OFF_CTRL, 32'h0);
    foreach (goodRun[i]) wr(`EMSM_OFF_CTRL, 32'(goodRun[i] << 2));
    hold(emsm_pkg::MODE_ACTIVE);
    wr(`EMSM_OFF_CTRL, 32'h8);
    wait_mode(emsm_pkg::MODE_SHUTOFF, 8'h00);
    core.wake(0, 4);
    core.wake(2, 4);
    hold(emsm_pkg::MODE_SHUTOFF);
    rst_cycle();
    wait_mode(emsm_pkg::MODE_ACTIVE, 8'hFF);
    axi_rd(`EMSM_OFF_CTRL);
    check(rd, 32'h0);
    $display("test shutoff done");
    close_out();
  end
endmodule

`default_nettype wire
